// *** design/agu_pkg.sv ***
package agu_pkg;

    // Field widths
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 9;
    localparam int OFFS_W = 7;
    localparam int SIMM_W = 8;
    localparam int SEL_W = 3;
    localparam int NUM_AUX = 8;
    localparam int NUM_CIRC = 2;
    localparam int REG_ADDR_W = 8;

    // Register offsets on the control port
    localparam logic [7:0] OFF_AUX_BASE = 8'h00;
    localparam logic [7:0] OFF_PAGE = 8'h08;
    localparam logic [7:0] OFF_SELECT = 8'h09;
    localparam logic [7:0] OFF_CIRC1_START = 8'h0a;
    localparam logic [7:0] OFF_CIRC1_END = 8'h0b;
    localparam logic [7:0] OFF_CIRC2_START = 8'h0c;
    localparam logic [7:0] OFF_CIRC2_END = 8'h0d;
    localparam logic [7:0] OFF_CIRC_CTRL = 8'h0e;
    localparam logic [7:0] OFF_STATUS = 8'h0f;
    localparam logic [7:0] OFF_LAST_ADDR = 8'h10;

    // Circular control fields: per buffer a select field and an enable bit
    localparam int CTRL_SEL1_LSB = 0;
    localparam int CTRL_EN1_BIT = 3;
    localparam int CTRL_SEL2_LSB = 4;
    localparam int CTRL_EN2_BIT = 7;
    localparam int CTRL_W = 8;

    // Reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [8:0] RST_PAGE = 9'h000;
    localparam logic [2:0] RST_SELECT = 3'h0;
    localparam logic [7:0] RST_CTRL = 8'h00;

    // Default external boundary and extra cycles for an external operand
    localparam logic [15:0] DEF_EXT_BASE = 16'h0800;
    localparam int DEF_EXT_EXTRA = 1;

    typedef enum logic [2:0] {
        MODE_DIRECT = 3'b000,
        MODE_INDIRECT = 3'b001,
        MODE_SHORT_IMM = 3'b010,
        MODE_LONG_IMM = 3'b011,
        MODE_MMAP = 3'b100
    } mode_t;

    typedef enum logic [2:0] {
        IND_NONE = 3'b000,
        IND_INC = 3'b001,
        IND_DEC = 3'b010,
        IND_ADD_INDEX = 3'b011,
        IND_SUB_INDEX = 3'b100,
        IND_REV_INC = 3'b101,
        IND_REV_DEC = 3'b110
    } ind_op_t;

    typedef struct packed {
        logic valid;
        mode_t mode;
        logic [6:0] offset;
        logic [7:0] short_imm;
        logic [15:0] long_imm;
        ind_op_t ind_op;
        logic sel_load;
        logic [2:0] sel_new;
    } req_t;

    typedef struct packed {
        logic valid;
        logic is_addr;
        logic external;
        logic [15:0] value;
    } resp_t;

endpackage : agu_pkg

// *** design/bitrev_addsub.sv ***
`timescale 1ns/1ps
`default_nettype none

module bitrev_addsub #(
    parameter int W = 16
) (
    input wire logic [W-1:0] base,
    input wire logic [W-1:0] step,
    input wire logic subtract,
    output logic [W-1:0] result
);

    logic [W-1:0] rev_base;
    logic [W-1:0] rev_step;
    logic [W-1:0] rev_sum;

    // Mirror operands so carry runs from the top bit downward
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_mirror
            assign rev_base[i] = base[W-1-i];
            assign rev_step[i] = step[W-1-i];
            assign result[i] = rev_sum[W-1-i];
        end
    endgenerate

    assign rev_sum = subtract ? rev_base - rev_step : rev_base + rev_step;

endmodule : bitrev_addsub

`default_nettype wire

// *** design/circ_wrap.sv ***
`timescale 1ns/1ps
`default_nettype none

module circ_wrap #(
    parameter int W = 16,
    parameter int SW = 3
) (
    input wire logic enable,
    input wire logic [SW-1:0] pointer_sel,
    input wire logic [SW-1:0] access_sel,
    input wire logic [W-1:0] pointer,
    input wire logic [W-1:0] start_addr,
    input wire logic [W-1:0] end_addr,
    output logic owned,
    output logic wrap
);

    // Enabled buffer claims the access when its pointer register is in use
    assign owned = enable && (pointer_sel == access_sel);
    // Last location reached: reload from start instead of stepping
    assign wrap = owned && (pointer == end_addr);

endmodule : circ_wrap

`default_nettype wire

// *** design/data_address_generator.sv ***
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module data_address_generator #(
    parameter logic [15:0] EXT_BASE = agu_pkg::DEF_EXT_BASE,
    parameter int EXT_EXTRA = agu_pkg::DEF_EXT_EXTRA
) (
    input wire logic clk,
    input wire logic resetn,
    input wire agu_pkg::req_t req,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output agu_pkg::resp_t resp,
    output logic stall,
    output logic [15:0] reg_rdata
);

    localparam int CW = (EXT_EXTRA < 2) ? 1 : $clog2(EXT_EXTRA + 1);
    // Pointer register that holds the index step
    localparam int INDEX_AUX = 0;

    // Refuse settings the wait counter cannot serve
    generate
        if (EXT_EXTRA < 1 || EXT_EXTRA > 255) begin : g_bad_extra
            $error("EXT_EXTRA must lie between 1 and 255");
        end
    endgenerate

    // Page and offset must tile the address; the selector must reach every pointer
    generate
        if (agu_pkg::PAGE_W + agu_pkg::OFFS_W != agu_pkg::ADDR_W) begin : g_bad_page
            $error("page and offset widths must add up to the address width");
        end
        if (agu_pkg::NUM_AUX != (1 << agu_pkg::SEL_W)) begin : g_bad_aux
            $error("selector width must match the pointer register count");
        end
        if (agu_pkg::NUM_CIRC * (agu_pkg::SEL_W + 1) > agu_pkg::CTRL_W) begin : g_bad_ctrl
            $error("control register too narrow for every circular buffer");
        end
    endgenerate

    // Architectural state beside its next value
    logic [15:0] aux_pointer_regs [agu_pkg::NUM_AUX];
    logic [15:0] next_aux_pointer_regs [agu_pkg::NUM_AUX];
    logic [8:0] data_page_pointer;
    logic [8:0] next_data_page_pointer;
    logic [2:0] aux_reg_selector;
    logic [2:0] next_aux_reg_selector;
    logic [15:0] circ_start [agu_pkg::NUM_CIRC];
    logic [15:0] next_circ_start [agu_pkg::NUM_CIRC];
    logic [15:0] circ_end [agu_pkg::NUM_CIRC];
    logic [15:0] next_circ_end [agu_pkg::NUM_CIRC];
    logic [7:0] circ_ctrl;
    logic [7:0] next_circ_ctrl;
    logic [CW-1:0] wait_count;
    logic [CW-1:0] next_wait_count;
    logic [15:0] last_addr;
    logic [15:0] next_last_addr;
    agu_pkg::resp_t next_resp;
    logic next_stall;
    logic [15:0] next_reg_rdata;

    // Decode helpers and wrap detector results
    logic [15:0] index_aux_reg;
    logic [15:0] cur_ar;
    logic [15:0] rev_result;
    logic rev_sub;
    logic take;
    logic [agu_pkg::NUM_CIRC-1:0] circ_owned;
    logic [agu_pkg::NUM_CIRC-1:0] circ_wrap_hit;
    logic [2:0] circ_sel [agu_pkg::NUM_CIRC];
    logic [agu_pkg::NUM_CIRC-1:0] circ_en;

    // Current pointer, index step and acceptance
    assign index_aux_reg = aux_pointer_regs[INDEX_AUX];
    assign cur_ar = aux_pointer_regs[aux_reg_selector];
    assign rev_sub = (req.ind_op == agu_pkg::IND_REV_DEC);
    assign take = req.valid && (wait_count == '0);

    // Pointer select and enable of each buffer
    assign circ_sel[0] = circ_ctrl[agu_pkg::CTRL_SEL1_LSB +: agu_pkg::SEL_W];
    assign circ_sel[1] = circ_ctrl[agu_pkg::CTRL_SEL2_LSB +: agu_pkg::SEL_W];
    assign circ_en[0] = circ_ctrl[agu_pkg::CTRL_EN1_BIT];
    assign circ_en[1] = circ_ctrl[agu_pkg::CTRL_EN2_BIT];

    // Bit-reversed index step for transform buffers
    bitrev_addsub #(
        .W(agu_pkg::ADDR_W)
    ) u_bitrev (
        .base(cur_ar),
        .step(index_aux_reg),
        .subtract(rev_sub),
        .result(rev_result)
    );

    // One wrap detector per circular buffer
    genvar b;
    generate
        for (b = 0; b < agu_pkg::NUM_CIRC; b++) begin : g_circ
            circ_wrap #(
                .W(agu_pkg::ADDR_W),
                .SW(agu_pkg::SEL_W)
            ) u_circ (
                .enable(circ_en[b]),
                .pointer_sel(circ_sel[b]),
                .access_sel(aux_reg_selector),
                .pointer(cur_ar),
                .start_addr(circ_start[b]),
                .end_addr(circ_end[b]),
                .owned(circ_owned[b]),
                .wrap(circ_wrap_hit[b])
            );
        end
    endgenerate

    // Operand formation, post-modification and wait count
    always_comb begin
        logic [15:0] addr;
        logic [15:0] modified;
        logic stepping_up;
        addr = agu_pkg::RST_WORD;
        modified = cur_ar;
        stepping_up = 1'b0;
        next_resp = '0;
        next_wait_count = (wait_count != '0) ? wait_count - CW'(1) : wait_count;
        next_last_addr = last_addr;
        next_data_page_pointer = data_page_pointer;
        next_aux_reg_selector = aux_reg_selector;
        next_circ_ctrl = circ_ctrl;
        for (int k = 0; k < agu_pkg::NUM_AUX; k++) begin
            next_aux_pointer_regs[k] = aux_pointer_regs[k];
        end
        for (int k = 0; k < agu_pkg::NUM_CIRC; k++) begin
            next_circ_start[k] = circ_start[k];
            next_circ_end[k] = circ_end[k];
        end

        if (take) begin
            next_resp.valid = 1'b1;
            case (req.mode)
                agu_pkg::MODE_DIRECT: begin
                    addr = {data_page_pointer, req.offset};
                    next_resp.is_addr = 1'b1;
                end
                agu_pkg::MODE_INDIRECT: begin
                    addr = cur_ar;
                    next_resp.is_addr = 1'b1;
                    case (req.ind_op)
                        agu_pkg::IND_INC: begin
                            modified = cur_ar + 16'h0001;
                            stepping_up = 1'b1;
                        end
                        agu_pkg::IND_DEC: modified = cur_ar - 16'h0001;
                        agu_pkg::IND_ADD_INDEX: begin
                            modified = cur_ar + index_aux_reg;
                            stepping_up = 1'b1;
                        end
                        agu_pkg::IND_SUB_INDEX: modified = cur_ar - index_aux_reg;
                        agu_pkg::IND_REV_INC: modified = rev_result;
                        agu_pkg::IND_REV_DEC: modified = rev_result;
                        agu_pkg::IND_NONE: modified = cur_ar;
                        default: modified = cur_ar;
                    endcase
                    // Pointer of an active buffer wraps on its end word
                    // Downward and bit-reversed steps never wrap
                    if (stepping_up && |circ_owned) begin
                        if (circ_wrap_hit[0]) begin
                            modified = circ_start[0];
                        end else if (circ_wrap_hit[1]) begin
                            modified = circ_start[1];
                        end
                    end
                    next_aux_pointer_regs[aux_reg_selector] = modified;
                end
                agu_pkg::MODE_SHORT_IMM: begin
                    next_resp.value = {8'h00, req.short_imm};
                end
                agu_pkg::MODE_LONG_IMM: begin
                    next_resp.value = req.long_imm;
                end
                agu_pkg::MODE_MMAP: begin
                    addr = {agu_pkg::RST_PAGE, req.offset};
                    next_resp.is_addr = 1'b1;
                end
                default: next_resp.valid = 1'b0;
            endcase
            if (next_resp.is_addr) begin
                next_resp.value = addr;
                next_last_addr = addr;
                // External operand costs extra cycles on the shared lines
                if (addr >= EXT_BASE) begin
                    next_resp.external = 1'b1;
                    next_wait_count = CW'(EXT_EXTRA);
                end
            end
            if (req.sel_load) begin
                next_aux_reg_selector = req.sel_new;
            end
        end

        // Software writes; they take precedence over a same-cycle update
        if (reg_write) begin
            // Pointer registers sit at the lowest offsets
            if (reg_addr < agu_pkg::OFF_PAGE) begin
                next_aux_pointer_regs[reg_addr[agu_pkg::SEL_W-1:0]] = reg_wdata;
            end
            case (reg_addr)
                agu_pkg::OFF_PAGE: next_data_page_pointer = reg_wdata[agu_pkg::PAGE_W-1:0];
                agu_pkg::OFF_SELECT: next_aux_reg_selector = reg_wdata[agu_pkg::SEL_W-1:0];
                agu_pkg::OFF_CIRC1_START: next_circ_start[0] = reg_wdata;
                agu_pkg::OFF_CIRC1_END: next_circ_end[0] = reg_wdata;
                agu_pkg::OFF_CIRC2_START: next_circ_start[1] = reg_wdata;
                agu_pkg::OFF_CIRC2_END: next_circ_end[1] = reg_wdata;
                agu_pkg::OFF_CIRC_CTRL: next_circ_ctrl = reg_wdata[agu_pkg::CTRL_W-1:0];
                default: next_circ_ctrl = next_circ_ctrl;
            endcase
        end
    end

    // Read data for the cycle after a read strobe
    always_comb begin
        next_reg_rdata = agu_pkg::RST_WORD;
        if (reg_read) begin
            // Pointer registers first, then the named offsets
            if (reg_addr < agu_pkg::OFF_PAGE) begin
                next_reg_rdata = aux_pointer_regs[reg_addr[agu_pkg::SEL_W-1:0]];
            end
            case (reg_addr)
                agu_pkg::OFF_PAGE: next_reg_rdata = {7'h00, data_page_pointer};
                agu_pkg::OFF_SELECT: next_reg_rdata = {13'h0000, aux_reg_selector};
                agu_pkg::OFF_CIRC1_START: next_reg_rdata = circ_start[0];
                agu_pkg::OFF_CIRC1_END: next_reg_rdata = circ_end[0];
                agu_pkg::OFF_CIRC2_START: next_reg_rdata = circ_start[1];
                agu_pkg::OFF_CIRC2_END: next_reg_rdata = circ_end[1];
                agu_pkg::OFF_CIRC_CTRL: next_reg_rdata = {8'h00, circ_ctrl};
                agu_pkg::OFF_STATUS: next_reg_rdata = {15'h0000, stall};
                agu_pkg::OFF_LAST_ADDR: next_reg_rdata = last_addr;
                default: next_reg_rdata = next_reg_rdata;
            endcase
        end
    end

    // Stall mirrors a nonzero wait count, registered beside it
    assign next_stall = (next_wait_count != '0);

    // State registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // Every register clears to zero
            for (int k = 0; k < agu_pkg::NUM_AUX; k++) begin
                aux_pointer_regs[k] <= agu_pkg::RST_WORD;
            end
            for (int k = 0; k < agu_pkg::NUM_CIRC; k++) begin
                circ_start[k] <= agu_pkg::RST_WORD;
                circ_end[k] <= agu_pkg::RST_WORD;
            end
            data_page_pointer <= agu_pkg::RST_PAGE;
            aux_reg_selector <= agu_pkg::RST_SELECT;
            circ_ctrl <= agu_pkg::RST_CTRL;
            wait_count <= '0;
            last_addr <= agu_pkg::RST_WORD;
            resp <= '0;
            stall <= 1'b0;
            reg_rdata <= agu_pkg::RST_WORD;
        end else begin
            for (int k = 0; k < agu_pkg::NUM_AUX; k++) begin
                aux_pointer_regs[k] <= next_aux_pointer_regs[k];
            end
            for (int k = 0; k < agu_pkg::NUM_CIRC; k++) begin
                circ_start[k] <= next_circ_start[k];
                circ_end[k] <= next_circ_end[k];
            end
            data_page_pointer <= next_data_page_pointer;
            aux_reg_selector <= next_aux_reg_selector;
            circ_ctrl <= next_circ_ctrl;
            wait_count <= next_wait_count;
            last_addr <= next_last_addr;
            resp <= next_resp;
            stall <= next_stall;
            reg_rdata <= next_reg_rdata;
        end
    end

endmodule : data_address_generator

`default_nettype wire

// *** dv/data_address_generator_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none

module data_address_generator_assertions #(
    parameter logic [15:0] EXT_BASE = agu_pkg::DEF_EXT_BASE,
    parameter int EXT_EXTRA = agu_pkg::DEF_EXT_EXTRA
) (
    input wire logic clk,
    input wire logic resetn,
    input wire agu_pkg::req_t req,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire agu_pkg::resp_t resp,
    input wire logic stall,
    input wire logic [15:0] reg_rdata
);
    logic [8:0] stall_run;
    logic [8:0] next_stall_run;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Count consecutive stall cycles
    always_comb begin
        next_stall_run = stall ? stall_run + 9'h001 : 9'h000;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stall_run <= 9'h000;
        end else begin
            stall_run <= next_stall_run;
        end
    end

    // A request taken in a given mode
    sequence s_take(agu_pkg::mode_t m);
        req.valid && !stall && req.mode == m;
    endsequence

    property p_direct;
        s_take(agu_pkg::MODE_DIRECT) |=> resp.valid && resp.is_addr && resp.value[6:0] == $past(req.offset);
    endproperty
    a_direct: assert property (p_direct) else $error("direct address lost its offset");
    property p_mmap;
        s_take(agu_pkg::MODE_MMAP) |=> resp.valid && resp.value == {9'h000, $past(req.offset)};
    endproperty
    a_mmap: assert property (p_mmap) else $error("page-zero address not on page zero");
    property p_short;
        s_take(agu_pkg::MODE_SHORT_IMM) |=> resp.valid && !resp.is_addr && resp.value == {8'h00, $past(req.short_imm)};
    endproperty
    a_short: assert property (p_short) else $error("short operand wrong");
    property p_long;
        s_take(agu_pkg::MODE_LONG_IMM) |=> resp.valid && !resp.is_addr && resp.value == $past(req.long_imm);
    endproperty
    a_long: assert property (p_long) else $error("long operand wrong");
    property p_idle;
        !(req.valid && !stall) |=> !resp.valid;
    endproperty
    a_idle: assert property (p_idle) else $error("response without a taken request");
    property p_ext;
        resp.valid && resp.is_addr |-> resp.external == (resp.value >= EXT_BASE);
    endproperty
    a_ext: assert property (p_ext) else $error("external flag wrong");
    property p_stall_start;
        resp.valid && resp.external |-> stall;
    endproperty
    a_stall_start: assert property (p_stall_start) else $error("no stall after external operand");
    property p_stall_len;
        stall |-> stall_run < EXT_EXTRA;
    endproperty
    a_stall_len: assert property (p_stall_len) else $error("stall too long");
    property p_stall_end;
        $fell(stall) |-> stall_run == EXT_EXTRA;
    endproperty
    a_stall_end: assert property (p_stall_end) else $error("stall too short");
    property p_rd_idle;
        !reg_read |=> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_page_rd;
        reg_read && reg_addr == agu_pkg::OFF_PAGE |=> reg_rdata[15:9] == 7'h00;
    endproperty
    a_page_rd: assert property (p_page_rd) else $error("page pointer wider than nine bits");
endmodule : data_address_generator_assertions

`default_nettype wire

// *** dv/decoder_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module decoder_model (
    input wire logic stall,
    input wire logic go,
    input wire agu_pkg::req_t cmd,
    output agu_pkg::req_t req
);
    // Hold the request off while stalled; idle fields carry junk
    always_comb begin
        req = ~cmd;
        req.valid = 1'b0;
        if (go && !stall) begin
            req = cmd;
        end
    end
endmodule : decoder_model

`default_nettype wire

// *** dv/data_address_generator_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end

module data_address_generator_tb;
    localparam logic [15:0] EXT = agu_pkg::DEF_EXT_BASE;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    agu_pkg::req_t cmd = '0;
    logic go = 1'b0;
    agu_pkg::req_t req;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    agu_pkg::resp_t resp;
    logic stall;
    logic [15:0] reg_rdata;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [15:0] mods [7] = '{16'h0048, 16'h0049, 16'h0047, 16'h0050, 16'h0040, 16'h0044, 16'h0040};

    data_address_generator #(.EXT_BASE(EXT), .EXT_EXTRA(1)) data_address_generator_inst (
        .clk(clk), .resetn(resetn), .req(req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .resp(resp), .stall(stall), .reg_rdata(reg_rdata));
    decoder_model decoder_model_inst (.stall(stall), .go(go), .cmd(cmd), .req(req));

    // Clock and hang guard
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask : rd

    // One decoder request and its checked response
    task automatic op(input agu_pkg::mode_t m, input agu_pkg::ind_op_t o, input logic [15:0] d,
                      input logic [3:0] s, input logic [15:0] ev);
        logic addr;
        addr = m inside {agu_pkg::MODE_DIRECT, agu_pkg::MODE_INDIRECT, agu_pkg::MODE_MMAP};
        @(posedge clk);
        cmd <= '{valid: 1'b1, mode: m, offset: d[6:0], short_imm: d[7:0], long_imm: d,
                 ind_op: o, sel_load: s[3], sel_new: s[2:0]};
        go <= 1'b1;
        do @(posedge clk); while (!req.valid);
        go <= 1'b0;
        #1;
        `CHK("resp.valid", 1'b1, resp.valid)
        `CHK("resp.value", ev, resp.value)
        `CHK("resp.is_addr", addr, resp.is_addr)
        `CHK("resp.external", addr && ev >= EXT, resp.external)
        `CHK("stall", addr && ev >= EXT, stall)
    endtask : op

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd(agu_pkg::OFF_PAGE, 16'h0000);
        wr(agu_pkg::OFF_PAGE, 16'hffff);
        rd(agu_pkg::OFF_PAGE, 16'h01ff);
        rd(8'h20, 16'h0000);
        // Direct and page-zero forms against a full page pointer
        op(agu_pkg::MODE_DIRECT, agu_pkg::IND_NONE, 16'h0000, 4'h0, 16'hff80);
        op(agu_pkg::MODE_MMAP, agu_pkg::IND_NONE, 16'h0045, 4'h0, 16'h0045);
        wr(agu_pkg::OFF_PAGE, 16'h0005);
        op(agu_pkg::MODE_DIRECT, agu_pkg::IND_NONE, 16'h007f, 4'h0, 16'h02ff);
        rd(agu_pkg::OFF_STATUS, 16'h0000);
        op(agu_pkg::MODE_SHORT_IMM, agu_pkg::IND_NONE, 16'h12a5, 4'h0, 16'h00a5);
        op(agu_pkg::MODE_LONG_IMM, agu_pkg::IND_NONE, 16'hbeef, 4'h0, 16'hbeef);
        // Every selector value, stepping the selector after each access
        for (int i = 0; i < 8; i++) begin
            wr(agu_pkg::OFF_AUX_BASE + i[7:0], 16'h0100 + 16'(i));
        end
        for (int i = 0; i < 8; i++) begin
            op(agu_pkg::MODE_INDIRECT, agu_pkg::IND_NONE, 16'h0000, {1'b1, 3'(i + 1)}, 16'h0100 + 16'(i));
        end
        for (int i = 0; i < 8; i++) begin
            rd(agu_pkg::OFF_AUX_BASE + i[7:0], 16'h0100 + 16'(i));
        end
        // Every post-modification form on one register
        wr(agu_pkg::OFF_AUX_BASE, 16'h0008);
        wr(agu_pkg::OFF_SELECT, 16'h0001);
        for (int k = 0; k < 7; k++) begin
            wr(agu_pkg::OFF_AUX_BASE + 8'h01, 16'h0048);
            op(agu_pkg::MODE_INDIRECT, agu_pkg::ind_op_t'(k), 16'h0000, 4'h0, 16'h0048);
            rd(agu_pkg::OFF_AUX_BASE + 8'h01, mods[k]);
        end
        // Two circular buffers, all bounds loaded first
        wr(agu_pkg::OFF_CIRC1_START, 16'h0200);
        wr(agu_pkg::OFF_CIRC1_END, 16'h0203);
        wr(agu_pkg::OFF_CIRC2_START, 16'h0300);
        wr(agu_pkg::OFF_CIRC2_END, 16'h0301);
        wr(agu_pkg::OFF_AUX_BASE + 8'h02, 16'h0200);
        wr(agu_pkg::OFF_AUX_BASE + 8'h03, 16'h0300);
        wr(agu_pkg::OFF_CIRC_CTRL, 16'h00ba);
        wr(agu_pkg::OFF_SELECT, 16'h0002);
        for (int i = 0; i < 6; i++) begin
            op(agu_pkg::MODE_INDIRECT, agu_pkg::IND_INC, 16'h0000, 4'hb, 16'h0200 + 16'(i % 4));
            op(agu_pkg::MODE_INDIRECT, agu_pkg::IND_INC, 16'h0000, 4'ha, 16'h0300 + 16'(i % 2));
        end
        rd(agu_pkg::OFF_LAST_ADDR, 16'h0301);
        // Reset in mid-run clears pointers, bounds, control and the last address
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(agu_pkg::OFF_AUX_BASE + 8'h02, 16'h0000);
        rd(agu_pkg::OFF_CIRC1_END, 16'h0000);
        rd(agu_pkg::OFF_CIRC_CTRL, 16'h0000);
        rd(agu_pkg::OFF_SELECT, 16'h0000);
        rd(agu_pkg::OFF_LAST_ADDR, 16'h0000);
        end_sim();
    end
endmodule : data_address_generator_tb

bind data_address_generator data_address_generator_assertions #(.EXT_BASE(EXT_BASE), .EXT_EXTRA(EXT_EXTRA)) chk_inst (
    .clk(clk), .resetn(resetn), .req(req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .resp(resp), .stall(stall), .reg_rdata(reg_rdata));

`default_nettype wire
